/* File: fsv_supervisor.sv */
`timescale 1ns/1ps
module fsv_supervisor #(
  parameter int TICK_CYCLES  = fsv_pkg::TICK_CYC,
  parameter int MAX_PERIOD   = fsv_pkg::MAX_PER_CYC,
  parameter int BURST_PERIOD = fsv_pkg::BURST_PER_CYC
) (
  input  wire logic        ref_clk,             // 125 MHz clock
  input  wire logic        rst,                 // Sync reset, high
  input  wire logic        supply_at_startup,   // Supply at start-up level
  input  wire logic        supply_lockout,      // Supply below lockout level
  input  wire logic        supply_below_start,  // Supply under start-up level
  input  wire logic        protect_ok,          // Protect above detect plus hysteresis
  input  wire logic        ctrl_start_ok,       // Control above start level
  input  wire logic        ctrl_regulated,      // Output in regulation
  input  wire logic        mains_adc_valid,     // Sample conversion done
  input  wire logic [7:0]  mains_adc,           // Sampled pin current code
  input  wire logic        demag_done,          // Demagnetization detected
  input  wire logic        valley_det,          // Valley detected
  input  wire logic        freq_at_max,         // Switching rate at its limit
  input  wire logic        fr_request,          // Medium power
  input  wire logic        burst_request,       // Low power
  input  wire logic        burst_demand,        // Loop asks for a packet
  input  wire logic [15:0] vco_period,          // Oscillator period, cycles
  output logic             circuitry_active,    // Internal circuitry on
  output logic             hv_charge_en,        // Supply charge from pin
  output logic             high_voltage_pin_pull, // Pin pulled to ground
  output logic             adc_start,           // Start conversion pulse
  output logic             softstart_charge,    // Soft-start charge on
  output logic             switching_en,        // Switching permitted
  output logic             cycle_start,         // New switching cycle pulse
  output logic             brownout_flag,       // Brownout detected
  output logic             mains_ok,            // Brown-in reached
  output logic             mains_disconnected,  // Mains gone, discharging
  output logic [1:0]       op_mode,             // Operating regime
  output logic             peak_limit_low       // Peak current at quarter
);
  // ****************************************
  // Millisecond tick
  // ****************************************
  logic tick;

  fsv_ms_tick #(
    .TICK_CYCLES (TICK_CYCLES)
  ) fsv_ms_tick_i (
    .ref_clk (ref_clk),
    .rst     (rst),
    .tick    (tick)
  );

  // ****************************************
  // Start-up sequencer
  // ****************************************
  fsv_pkg::fsv_state_t st_q, st_d;
  logic                reg_seen_q, reg_seen_d;
  logic                chg_q, chg_d;
  logic                act_q, act_d;
  logic                ss_q, ss_d;
  logic                brownout_q;
  logic                mains_ok_q;
  logic                active;

  assign active = st_q != fsv_pkg::ST_OFF;

  always_comb begin
    st_d       = st_q;
    reg_seen_d = reg_seen_q;
    case (st_q)
      fsv_pkg::ST_OFF: begin
        reg_seen_d = 1'b0;
        if (supply_at_startup) begin
          st_d = fsv_pkg::ST_WAIT;
        end
      end
      fsv_pkg::ST_WAIT: begin
        if (protect_ok && ctrl_start_ok && mains_ok_q) begin
          st_d = fsv_pkg::ST_RUN;
        end
      end
      fsv_pkg::ST_RUN: begin
        if (ctrl_regulated) begin
          reg_seen_d = 1'b1;
        end
        if (brownout_q) begin
          st_d       = fsv_pkg::ST_FAULT;
          reg_seen_d = 1'b0;
        end
      end
      fsv_pkg::ST_FAULT: begin
        if (mains_ok_q) begin
          st_d = fsv_pkg::ST_WAIT;
        end
      end
      default: st_d = fsv_pkg::ST_OFF;
    endcase
    if (supply_lockout) begin
      st_d       = fsv_pkg::ST_OFF;
      reg_seen_d = 1'b0;
    end
    chg_d = supply_below_start && !(st_d == fsv_pkg::ST_RUN && reg_seen_d);
    act_d = st_d != fsv_pkg::ST_OFF;
    ss_d  = st_d == fsv_pkg::ST_RUN;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_q       <= fsv_pkg::ST_OFF;
      reg_seen_q <= 1'b0;
      chg_q      <= 1'b0;
      act_q      <= 1'b0;
      ss_q       <= 1'b0;
    end else begin
      st_q       <= st_d;
      reg_seen_q <= reg_seen_d;
      chg_q      <= chg_d;
      act_q      <= act_d;
      ss_q       <= ss_d;
    end
  end

  // ****************************************
  // Mains sampling and supervision
  // ****************************************
  logic       pull_q, pull_d;
  logic       start_q, start_d;
  logic       busy_q, busy_d;
  logic [7:0] prev_q, prev_d;
  logic [6:0] susp_q, susp_d;
  logic [6:0] bo_cnt_q, bo_cnt_d;
  logic [6:0] dc_cnt_q, dc_cnt_d;
  logic       disc_q, disc_d;
  logic       brownout_d;
  logic       mains_ok_d;
  logic       slope;
  logic       in_burst;

  always_comb begin
    pull_d     = pull_q;
    start_d    = 1'b0;
    busy_d     = busy_q;
    prev_d     = prev_q;
    susp_d     = susp_q;
    bo_cnt_d   = bo_cnt_q;
    dc_cnt_d   = dc_cnt_q;
    disc_d     = disc_q;
    brownout_d = brownout_q;
    mains_ok_d = mains_ok_q;
    slope      = 1'b0;
    if (!active) begin
      pull_d   = 1'b0;
      busy_d   = 1'b0;
      susp_d   = 7'h00;
      bo_cnt_d = 7'h00;
      dc_cnt_d = 7'h00;
      disc_d   = 1'b0;
    end else begin
      if (tick) begin
        if (susp_q != 7'h00) begin
          susp_d = susp_q - 7'h01;
        end else begin
          if (!busy_q) begin
            pull_d  = 1'b1;
            start_d = 1'b1;
            busy_d  = 1'b1;
          end
          if (bo_cnt_q != 7'h7F) begin
            bo_cnt_d = bo_cnt_q + 7'h01;
          end
          if (dc_cnt_q != 7'h7F) begin
            dc_cnt_d = dc_cnt_q + 7'h01;
          end
        end
      end
      if (busy_q && mains_adc_valid) begin
        busy_d = 1'b0;
        pull_d = disc_q;
        prev_d = mains_adc;
        slope  = (prev_q < fsv_pkg::BROWNIN_CODE && mains_adc >= fsv_pkg::BROWNIN_CODE)
              || (prev_q < fsv_pkg::MAINS_HI_CODE
                  && mains_adc >= fsv_pkg::MAINS_HI_CODE);
        if (mains_adc >= fsv_pkg::BROWNOUT_CODE) begin
          bo_cnt_d = 7'h00;
        end
        if (mains_adc >= fsv_pkg::BROWNIN_CODE) begin
          mains_ok_d = 1'b1;
          brownout_d = 1'b0;
        end
        if (slope) begin
          dc_cnt_d = 7'h00;
          disc_d   = 1'b0;
          pull_d   = 1'b0;
          susp_d   = in_burst ? fsv_pkg::SUSP_B_TICKS : fsv_pkg::SUSP_TICKS;
        end
      end
      if (bo_cnt_q >= fsv_pkg::BROWNOUT_TICKS) begin
        brownout_d = 1'b1;
        mains_ok_d = 1'b0;
      end
      if (dc_cnt_q >= fsv_pkg::DISC_TICKS && !slope) begin
        disc_d = 1'b1;
        pull_d = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pull_q     <= 1'b0;
      start_q    <= 1'b0;
      busy_q     <= 1'b0;
      prev_q     <= 8'h00;
      susp_q     <= 7'h00;
      bo_cnt_q   <= 7'h00;
      dc_cnt_q   <= 7'h00;
      disc_q     <= 1'b0;
      brownout_q <= 1'b0;
      mains_ok_q <= 1'b0;
    end else begin
      pull_q     <= pull_d;
      start_q    <= start_d;
      busy_q     <= busy_d;
      prev_q     <= prev_d;
      susp_q     <= susp_d;
      bo_cnt_q   <= bo_cnt_d;
      dc_cnt_q   <= dc_cnt_d;
      disc_q     <= disc_d;
      brownout_q <= brownout_d;
      mains_ok_q <= mains_ok_d;
    end
  end

  // ****************************************
  // Operating regime and burst packets
  // ****************************************
  fsv_pkg::fsv_mode_t mode_q, mode_d;
  logic [17:0]        gap_q, gap_d;
  logic               pkt_q, pkt_d;
  logic               sw_q, sw_d;
  logic               plim_q, plim_d;
  logic               run;

  assign run      = st_q == fsv_pkg::ST_RUN && !brownout_q;
  assign in_burst = mode_q == fsv_pkg::MODE_BURST;

  always_comb begin
    mode_d = fsv_pkg::MODE_QR;
    if (burst_request) begin
      mode_d = fsv_pkg::MODE_BURST;
    end else if (fr_request) begin
      mode_d = fsv_pkg::MODE_FR;
    end else if (freq_at_max) begin
      mode_d = fsv_pkg::MODE_DCM;
    end
    if (!run) begin
      mode_d = fsv_pkg::MODE_QR;
    end
    plim_d = mode_d == fsv_pkg::MODE_FR || mode_d == fsv_pkg::MODE_DCM;
    gap_d  = (gap_q == 18'h3FFFF) ? gap_q : gap_q + 18'h00001;
    pkt_d  = pkt_q;
    if (mode_d != fsv_pkg::MODE_BURST || !burst_demand) begin
      pkt_d = 1'b0;
    end else if (!pkt_q && gap_q >= 18'(BURST_PERIOD - 1)) begin
      pkt_d = 1'b1;
      gap_d = 18'h00000;
    end
    sw_d = run && (mode_d != fsv_pkg::MODE_BURST || pkt_d);
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode_q <= fsv_pkg::MODE_QR;
      gap_q  <= 18'h3FFFF;
      pkt_q  <= 1'b0;
      sw_q   <= 1'b0;
      plim_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      gap_q  <= gap_d;
      pkt_q  <= pkt_d;
      sw_q   <= sw_d;
      plim_q <= plim_d;
    end
  end

  // ****************************************
  // Switching cycle gate
  // ****************************************
  fsv_cycle_gate #(
    .MAX_PERIOD (MAX_PERIOD)
  ) fsv_cycle_gate_i (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .enable      (sw_q),
    .mode        (mode_q),
    .demag_done  (demag_done),
    .valley_det  (valley_det),
    .vco_period  (vco_period),
    .cycle_start (cycle_start)
  );

  // ****************************************
  // Outputs
  // ****************************************
  assign circuitry_active      = act_q;
  assign hv_charge_en          = chg_q;
  assign high_voltage_pin_pull = pull_q;
  assign adc_start             = start_q;
  assign softstart_charge      = ss_q;
  assign switching_en          = sw_q;
  assign brownout_flag         = brownout_q;
  assign mains_ok              = mains_ok_q;
  assign mains_disconnected    = disc_q;
  assign op_mode               = mode_q;
  assign peak_limit_low        = plim_q;
endmodule // fsv_supervisor

/* File: fsv_pkg.sv */
// Notes on behaviour
// - Keep internal circuitry off until supply reaches start-up level, then activate.
// - Start switching only with protect, control and mains brown-in all satisfied.
// - Regulate supply via high-voltage charge until control input shows regulation.
// - Sample mains each millisecond by pulling the high-voltage pin to ground.
// - Allow switching only after a mains sample exceeded brown-in.
// - Flag brownout and stop after 30 ms of samples below brownout level.
// - Compute rising mains per sample; a rising edge proves mains connected.
// - Rising edge means successive samples cross brown-in or mains-high threshold.
// - After mains detection pause sampling 6 ms, or 97 ms in burst.
// - No rising edge for 28 ms means disconnected; hold pin pulled down.
// - Quasi-resonant cycles start only after demagnetization and a valley.
// - At maximum frequency move to discontinuous mode with valley skipping.
// - Frequency reduction: oscillator sets rate down to 25 kHz, valley switching kept.
// - Burst mode at low power; switching never below 25 kHz.
// - Burst packets repeat below 800 Hz.
// - Frequency reduction and discontinuous modes cap peak current near 25 percent.
// - Brownout stops switching; restart only after mains exceeds brown-in again.
package fsv_pkg;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ        = 125_000_000;
  localparam int TICK_MS       = 1;
  localparam int TICK_CYC      = CLK_HZ / 1000 * TICK_MS;
  localparam int BROWNOUT_MS   = 30;
  localparam int DISCONNECT_MS = 28;
  localparam int SUSPEND_MS    = 6;
  localparam int SUSP_BURST_MS = 97;
  localparam int MIN_SW_HZ     = 25_000;
  localparam int MAX_PER_CYC   = CLK_HZ / MIN_SW_HZ;
  localparam int MAX_SW_HZ     = 125_000;
  localparam int MIN_PER_CYC   = (CLK_HZ + MAX_SW_HZ - 1) / MAX_SW_HZ;
  localparam int BURST_MAX_HZ  = 800;
  localparam int BURST_PER_CYC = (CLK_HZ + BURST_MAX_HZ - 1) / BURST_MAX_HZ;

  localparam logic [6:0] BROWNOUT_TICKS = 7'(BROWNOUT_MS / TICK_MS);
  localparam logic [6:0] DISC_TICKS     = 7'(DISCONNECT_MS / TICK_MS);
  localparam logic [6:0] SUSP_TICKS     = 7'(SUSPEND_MS / TICK_MS);
  localparam logic [6:0] SUSP_B_TICKS   = 7'(SUSP_BURST_MS / TICK_MS);

  // ****************************************
  // Mains current thresholds (ADC codes)
  // ****************************************
  localparam logic [7:0] BROWNOUT_CODE  = 8'h50;
  localparam logic [7:0] BROWNIN_CODE   = 8'h60;
  localparam logic [7:0] MAINS_HI_CODE  = 8'hC0;

  // ****************************************
  // States and modes
  // ****************************************
  typedef enum logic [1:0] {
    ST_OFF   = 2'h0,
    ST_WAIT  = 2'h1,
    ST_RUN   = 2'h3,
    ST_FAULT = 2'h2
  } fsv_state_t;

  typedef enum logic [1:0] {
    MODE_QR    = 2'h0,
    MODE_DCM   = 2'h1,
    MODE_FR    = 2'h3,
    MODE_BURST = 2'h2
  } fsv_mode_t;
endpackage

/* File: fsv_ms_tick.sv */
`timescale 1ns/1ps
module fsv_ms_tick #(
  parameter int TICK_CYCLES = fsv_pkg::TICK_CYC
) (
  input  wire logic ref_clk,   // Clock
  input  wire logic rst,       // Sync reset
  output logic      tick       // One-cycle ms pulse
);
  logic [16:0] cnt_q, cnt_d;
  logic        tick_q, tick_d;

  always_comb begin
    tick_d = 1'b0;
    cnt_d  = cnt_q + 17'h00001;
    if (cnt_q == 17'(TICK_CYCLES - 1)) begin
      cnt_d  = 17'h00000;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_q  <= 17'h00000;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;
endmodule // fsv_ms_tick

/* File: fsv_cycle_gate.sv */
`timescale 1ns/1ps
module fsv_cycle_gate #(
  parameter int MAX_PERIOD = fsv_pkg::MAX_PER_CYC,
  parameter int MIN_PERIOD = fsv_pkg::MIN_PER_CYC
) (
  input  wire logic        ref_clk,     // Clock
  input  wire logic        rst,         // Sync reset
  input  wire logic        enable,      // Switching allowed
  input  wire logic [1:0]  mode,        // Operating mode
  input  wire logic        demag_done,  // Demagnetization seen
  input  wire logic        valley_det,  // Valley seen
  input  wire logic [15:0] vco_period,  // Oscillator period, cycles
  output logic             cycle_start  // One-cycle start pulse
);
  logic [15:0] cnt_q, cnt_d;
  logic        demag_q, demag_d;
  logic        start_q, start_d;
  logic        valley_ok;
  logic        hit_max;

  always_comb begin
    cnt_d     = (cnt_q == 16'hFFFF) ? cnt_q : cnt_q + 16'h0001;
    demag_d   = demag_q | demag_done;
    start_d   = 1'b0;
    valley_ok = demag_q & valley_det;
    hit_max   = cnt_q >= 16'(MAX_PERIOD - 1);
    case (fsv_pkg::fsv_mode_t'(mode))
      fsv_pkg::MODE_QR:    start_d = valley_ok;
      fsv_pkg::MODE_DCM:   start_d = valley_ok && cnt_q >= 16'(MIN_PERIOD - 1);
      fsv_pkg::MODE_FR:    start_d = (valley_ok && cnt_q >= vco_period) || hit_max;
      fsv_pkg::MODE_BURST: start_d = (valley_ok && cnt_q >= 16'(MIN_PERIOD - 1))
                                     || hit_max;
      default:             start_d = 1'b0;
    endcase
    if (!enable) begin
      start_d = 1'b0;
      demag_d = 1'b0;
      cnt_d   = 16'h0000;
    end else if (start_d) begin
      demag_d = 1'b0;
      cnt_d   = 16'h0000;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_q   <= 16'h0000;
      demag_q <= 1'b0;
      start_q <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      demag_q <= demag_d;
      start_q <= start_d;
    end
  end

  assign cycle_start = start_q;
endmodule // fsv_cycle_gate

/* File: fsv_supervisor_checker.sv */
`timescale 1ns/1ps
module fsv_supervisor_checker #(
  parameter int TICK_CYCLES  = 50,
  parameter int MAX_PERIOD   = 40,
  parameter int BURST_PERIOD = 300
) (
  input wire logic       ref_clk,               // Clock
  input wire logic       rst,                   // Reset
  input wire logic       supply_lockout,        // Lockout
  input wire logic       supply_below_start,    // Supply low
  input wire logic       protect_ok,            // Protect ok
  input wire logic       ctrl_start_ok,         // Control ok
  input wire logic       valley_det,            // Valley
  input wire logic       circuitry_active,      // Active
  input wire logic       hv_charge_en,          // Charge
  input wire logic       high_voltage_pin_pull, // Pin pull
  input wire logic       adc_start,             // Sample start
  input wire logic       softstart_charge,      // Soft start
  input wire logic       switching_en,          // Switching
  input wire logic       cycle_start,           // Cycle pulse
  input wire logic       brownout_flag,         // Brownout
  input wire logic       mains_ok,              // Brown-in
  input wire logic       mains_disconnected,    // Disconnected
  input wire logic [1:0] op_mode,               // Mode
  input wire logic       peak_limit_low         // Peak cap
);
  // ****************************************
  // Gap counters
  // ****************************************
  logic [15:0] per_q, per_d;
  logic [19:0] gap_q, gap_d;
  logic        sw_q, sw_d;
  always_comb begin
    per_d = per_q + 16'h0001;
    if (cycle_start || !switching_en || op_mode == fsv_pkg::MODE_QR
        || op_mode == fsv_pkg::MODE_DCM) begin
      per_d = 16'h0000;
    end
    gap_d = (gap_q == 20'hFFFFF) ? gap_q : gap_q + 20'h00001;
    if (switching_en && !sw_q && op_mode == fsv_pkg::MODE_BURST) begin
      gap_d = 20'h00000;
    end
    sw_d = switching_en;
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      per_q <= 16'h0000;
      gap_q <= 20'hFFFFF;
      sw_q  <= 1'b0;
    end else begin
      per_q <= per_d;
      gap_q <= gap_d;
      sw_q  <= sw_d;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ****************************************
  // Properties
  // ****************************************
  a_lockout_off: assert property (supply_lockout |=> !circuitry_active)
    else $error("active in lockout");
  a_start_gate: assert property ($rose(softstart_charge) |-> $past(protect_ok)
    && $past(ctrl_start_ok) && $past(mains_ok)) else $error("start without conditions");
  a_charge_cause: assert property (hv_charge_en |-> $past(supply_below_start))
    else $error("charge with supply high");
  a_sample_pulse: assert property (adc_start |-> high_voltage_pin_pull ##1 !adc_start)
    else $error("sample pulse bad");
  a_switch_mains: assert property ($rose(switching_en) |-> mains_ok)
    else $error("switching before brown-in");
  a_brownout_stop: assert property ($rose(brownout_flag)
    |-> !mains_ok ##[0:2] !switching_en) else $error("brownout did not stop");
  a_disc_pull: assert property (mains_disconnected |-> high_voltage_pin_pull)
    else $error("disconnect without pull");
  a_qr_valley: assert property (cycle_start && op_mode == fsv_pkg::MODE_QR
    |-> $past(valley_det) && $past(switching_en)) else $error("qr start without valley");
  a_peak_cap: assert property ((op_mode == fsv_pkg::MODE_FR
    || op_mode == fsv_pkg::MODE_DCM) |-> ##[0:1] peak_limit_low) else $error("peak cap missing");
  a_min_rate: assert property (int'(per_q) <= MAX_PERIOD + 2)
    else $error("switching rate too low");
  a_burst_gap: assert property ($rose(switching_en) && op_mode == fsv_pkg::MODE_BURST
    |-> int'(gap_q) >= BURST_PERIOD - 1) else $error("burst packets too close");
endmodule // fsv_supervisor_checker

bind fsv_supervisor fsv_supervisor_checker #(.TICK_CYCLES(TICK_CYCLES),
  .MAX_PERIOD(MAX_PERIOD), .BURST_PERIOD(BURST_PERIOD)) fsv_supervisor_checker_i (
  .ref_clk, .rst, .supply_lockout, .supply_below_start, .protect_ok, .ctrl_start_ok,
  .valley_det, .circuitry_active, .hv_charge_en, .high_voltage_pin_pull, .adc_start,
  .softstart_charge, .switching_en, .cycle_start, .brownout_flag, .mains_ok,
  .mains_disconnected, .op_mode, .peak_limit_low);

/* File: fsv_mains_model.sv */
`timescale 1ns/1ps
module fsv_mains_model (
  input  wire logic       ref_clk,   // Clock
  input  wire logic       adc_start, // Conversion request
  input  wire logic [7:0] level,     // Mains code to report
  output logic            valid,     // Result strobe
  output logic [7:0]      code       // Result, scrambled when idle
);
  logic [2:0] dly;
  logic [7:0] last;
  initial begin
    dly   = 3'h0;
    valid = 1'b0;
    last  = 8'h00;
    code  = 8'hFF;
  end
  // Result a few cycles after the pin is pulled
  always @(negedge ref_clk) begin
    valid <= 1'b0;
    code  <= ~last;
    if (adc_start === 1'b1) begin
      dly <= 3'h3;
    end else if (dly != 3'h0) begin
      dly <= dly - 3'h1;
      if (dly == 3'h1) begin
        valid <= 1'b1;
        code  <= level;
        last  <= level;
      end
    end
  end
endmodule // fsv_mains_model

/* File: fsv_supervisor_tb.sv */
`timescale 1ns/1ps
module fsv_supervisor_tb;
  localparam int TK = 50;
  localparam int MP = 40;
  localparam int BP = 300;
  logic        ref_clk, rst, supply_at_startup, supply_lockout, supply_below_start;
  logic        protect_ok, ctrl_start_ok, ctrl_regulated, mains_adc_valid, demag_done;
  logic        valley_det, freq_at_max, fr_request, burst_request, burst_demand;
  logic        circuitry_active, hv_charge_en, high_voltage_pin_pull, adc_start;
  logic        softstart_charge, switching_en, cycle_start, brownout_flag, mains_ok;
  logic        mains_disconnected, peak_limit_low;
  logic [7:0]  mains_adc, level;
  logic [1:0]  op_mode;
  logic [15:0] vco_period;
  int          error_cnt, n_tests, n_cyc, k, c0;

  fsv_supervisor #(.TICK_CYCLES(TK), .MAX_PERIOD(MP), .BURST_PERIOD(BP)) fsv_supervisor_i (
    .ref_clk, .rst, .supply_at_startup, .supply_lockout, .supply_below_start, .protect_ok,
    .ctrl_start_ok, .ctrl_regulated, .mains_adc_valid, .mains_adc, .demag_done, .valley_det,
    .freq_at_max, .fr_request, .burst_request, .burst_demand, .vco_period, .circuitry_active,
    .hv_charge_en, .high_voltage_pin_pull, .adc_start, .softstart_charge, .switching_en,
    .cycle_start, .brownout_flag, .mains_ok, .mains_disconnected, .op_mode, .peak_limit_low);
  fsv_mains_model fsv_mains_model_i (.ref_clk, .adc_start, .level, .valid(mains_adc_valid),
    .code(mains_adc));

  always #4 ref_clk = ~ref_clk;
  always @(negedge ref_clk) #2 if (cycle_start === 1'b1) n_cyc++;

  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string m);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t %s", $time, m);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic wrap_up();
    $display("tests=%0d mismatches=%0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic next_gap(output int g);
    g = 0;
    for (int i = 0; i < 600 && adc_start !== 1'b1; i++) step(1);
    step(1);
    while (g < 600 && adc_start !== 1'b1) begin
      step(1);
      g++;
    end
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    step(1);
    chk({circuitry_active, switching_en, high_voltage_pin_pull}, 3'h0, "reset");
    chk(op_mode, fsv_pkg::MODE_QR, "reset mode");
    $display("done reset");
  endtask
  task automatic t_start();
    level = 8'h70;
    supply_below_start = 1'b1;
    supply_at_startup = 1'b1;
    step(2);
    chk(circuitry_active, 1'b1, "active");
    chk(hv_charge_en, 1'b1, "charge");
    for (int i = 0; i < 4 * TK && mains_ok !== 1'b1; i++) step(1);
    chk(mains_ok, 1'b1, "brown-in");
    chk(softstart_charge, 1'b0, "early start");
    level = 8'hB0;
    next_gap(k);
    chk(k >= TK - 2 && k <= TK + 2, 1'b1, "plain gap");
    level = 8'hD0;
    next_gap(k);
    chk(k >= 6 * TK && k <= 8 * TK, 1'b1, "suspend gap");
    level = 8'h70;
    protect_ok = 1'b1;
    step(3);
    chk(softstart_charge, 1'b0, "one condition");
    ctrl_start_ok = 1'b1;
    step(3);
    chk({softstart_charge, switching_en}, 2'h3, "started");
    $display("done start");
  endtask
  task automatic t_qr();
    c0 = n_cyc;
    demag_done = 1'b1;
    step(1);
    demag_done = 1'b0;
    step(5);
    chk(n_cyc - c0, 0, "no valley");
    valley_det = 1'b1;
    step(4);
    valley_det = 1'b0;
    chk(n_cyc - c0, 1, "valley start");
    ctrl_regulated = 1'b1;
    step(3);
    chk(hv_charge_en, 1'b0, "regulated");
    $display("done qr");
  endtask
  task automatic t_modes();
    logic [2:0] req [4] = '{3'h4, 3'h2, 3'h1, 3'h0};
    logic [1:0] md [4] = '{fsv_pkg::MODE_DCM, fsv_pkg::MODE_FR, fsv_pkg::MODE_BURST,
                           fsv_pkg::MODE_QR};
    logic       pk [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
    for (int i = 0; i < 4; i++) begin
      {freq_at_max, fr_request, burst_request} = req[i];
      c0 = n_cyc;
      step(3 * MP);
      chk(op_mode, md[i], "mode");
      chk(peak_limit_low, pk[i], "peak cap");
      if (i == 1) chk(n_cyc - c0 >= 2, 1'b1, "fr rate");
    end
    $display("done modes");
  endtask
  task automatic t_burst();
    burst_request = 1'b1;
    burst_demand = 1'b1;
    step(20);
    chk(switching_en, 1'b1, "packet");
    burst_demand = 1'b0;
    step(5);
    chk(switching_en, 1'b0, "packet end");
    burst_demand = 1'b1;
    step(50);
    chk(switching_en, 1'b0, "packet gap");
    for (k = 0; k < 2 * BP && switching_en !== 1'b1; k++) step(1);
    chk(k >= BP - 100 && k <= BP - 50, 1'b1, "gap end");
    burst_demand = 1'b0;
    burst_request = 1'b0;
    step(3);
    $display("done burst");
  endtask
  task automatic t_brown();
    level = 8'h40;
    step(10 * TK);
    chk(brownout_flag, 1'b0, "short dip");
    level = 8'h70;
    step(10 * TK);
    level = 8'h40;
    for (k = 0; k < 60 * TK && brownout_flag !== 1'b1; k++) step(1);
    chk({mains_disconnected, high_voltage_pin_pull}, 2'h3, "discharge");
    step(3);
    chk({brownout_flag, switching_en}, 2'h2, "brownout stop");
    chk(hv_charge_en, 1'b1, "recharge");
    level = 8'h70;
    for (k = 0; k < 60 * TK && mains_ok !== 1'b1; k++) step(1);
    step(4);
    chk(mains_disconnected, 1'b0, "reconnect");
    chk({brownout_flag, switching_en}, 2'h1, "resume");
    supply_lockout = 1'b1;
    step(2);
    chk(circuitry_active, 1'b0, "lockout");
    $display("done brownout");
  endtask

  initial begin
    {ref_clk, supply_at_startup, supply_lockout, supply_below_start, protect_ok} = 5'h00;
    {ctrl_start_ok, ctrl_regulated, demag_done, valley_det, freq_at_max} = 5'h00;
    {fr_request, burst_request, burst_demand} = 3'h0;
    rst = 1'b1;
    level = 8'h00;
    vco_period = 16'h0014;
    error_cnt = 0;
    n_tests = 0;
    n_cyc = 0;
    step(5);
    rst = 1'b0;
    t_reset();
    t_start();
    t_qr();
    t_modes();
    t_burst();
    t_brown();
    wrap_up();
  end
  initial begin
    #(20000 * 8);
    error_cnt++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    wrap_up();
  end
endmodule // fsv_supervisor_tb
